// >>> sim/lcd_panel_model.sv
`timescale 1ns/1ps
module lcd_panel_model #(
   parameter logic [7:0] BUSY_VAL = 8'h3c
) (
   input  wire logic       sys_clk,
   input  wire logic       cs,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic       rs,
   input  wire logic [7:0] dout,
   input  wire logic       oe,
   input  wire logic       scl_out,
   input  wire logic       sda_out,
   output logic      [7:0] din,
   input  wire logic       scl_oe,
   input  wire logic       sda_oe,
   input  wire logic       sda_hold,
   output logic            scl_in,
   output logic            sda_in,
   output logic      [7:0] cmd_r,
   output logic      [7:0] dat_r
);
   logic [7:0] last_r = 8'h00;
   // latch written bytes, remember last byte driven
   always @(posedge sys_clk) begin
      if (cs && wr && oe) begin
         if (rs) dat_r <= dout;
         else cmd_r <= dout;
      end
      if (cs && rd) last_r <= din;
   end
   // answer only under the read strobe, else drive the inverse of the last byte read
   assign din = (cs && rd) ? (rs ? dat_r : BUSY_VAL) : ~last_r;
   // pulled-up lines, the expander may hold data low
   assign scl_in = scl_oe ? scl_out : 1'b1;
   assign sda_in = (sda_oe ? sda_out : 1'b1) && !sda_hold;
endmodule : lcd_panel_model

// >>> sim/lcd_parallel_touch_port_tb.sv
`timescale 1ns/1ps
module lcd_parallel_touch_port_tb;
   import lcd_port_pkg::*;
   localparam logic [7:0] BUSY_VAL = 8'h3c;
   logic        sys_clk = 0;
   logic        rst = 1;
   logic [1:0]  psel = 0;
   logic        pen = 0;
   logic        pw = 0;
   logic [11:0] pa = 0;
   logic [31:0] pd = 0;
   logic        sda_hold = 0;
   logic [31:0] lrdata, trdata, q;
   logic [7:0]  din, dout, cmd_r, dat_r;
   logic        cs, wr, rd, rs, rstl, bl, irq, scl_in, sda_in, scl_oe, sda_oe;
   logic        doe, scl_out, sda_out;
   int          n_mismatch = 0;
   int          num_checks = 0;

   initial forever #20 sys_clk = ~sys_clk;

   lcd_parallel_touch_port i_dut (.sys_clk, .rst, .lcd_psel(psel[0]), .lcd_penable(pen),
      .lcd_pwrite(pw), .lcd_paddr(pa), .lcd_pwdata(pd), .lcd_prdata(lrdata), .lcd_pready(),
      .lcd_pslverr(), .tw_psel(psel[1]), .tw_penable(pen), .tw_pwrite(pw), .tw_paddr(pa),
      .tw_pwdata(pd), .tw_prdata(trdata), .tw_pready(), .tw_pslverr(), .lcd_data_in(din),
      .lcd_data_out(dout), .lcd_data_oe(doe), .lcd_chip_select(cs), .lcd_write_strobe(wr),
      .lcd_read_strobe(rd), .lcd_register_select(rs), .lcd_reset_line(rstl),
      .lcd_backlight(bl), .lcd_done_irq(irq), .scl_in, .scl_out, .scl_oe, .sda_in,
      .sda_out, .sda_oe);
   lcd_panel_model #(.BUSY_VAL(BUSY_VAL)) i_panel (.sys_clk, .cs, .wr, .rd, .rs, .dout,
      .oe(doe), .scl_out, .sda_out, .din, .scl_oe, .sda_oe, .sda_hold, .scl_in, .sda_in,
      .cmd_r, .dat_r);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one zero-wait transfer, s picks the two-wire slot
   task automatic apb(input int s, input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel[s] <= 1;
      pw <= w;
      pa <= a;
      pd <= d;
      @(posedge sys_clk);
      pen <= 1;
      @(posedge sys_clk);
      q = s ? trdata : lrdata;
      psel[s] <= 0;
      pen <= 0;
   endtask : apb
   // poll the done flag with a bounded count
   task automatic poll;
      q = 0;
      for (int i = 0; i < 20 && !q[0]; i++) apb(0, 0, OFS_DONE_RAW, 0);
      chk(q[0], 1);
   endtask : poll
   // line read after the two-flop sync latency
   task automatic rd_tw;
      repeat (3) @(posedge sys_clk);
      apb(1, 0, OFS_TW_LINE, 0);
   endtask : rd_tw
   task automatic t_pins;
      apb(0, 1, OFS_PIN_CTRL, 32'hffff_ffff);
      apb(0, 0, OFS_PIN_CTRL, 0);
      chk(q, 32'h7b);
      chk({bl, rd, rs, rstl, wr, cs}, 6'h3f);
      apb(0, 1, OFS_PIN_CTRL, 0);
      apb(0, 1, 12'h020, 32'h1);
      apb(0, 0, 12'h020, 0);
      chk(q, 0);
   endtask : t_pins
   task automatic t_data;
      apb(0, 1, OFS_DATA, 32'hff5a);
      poll;
      chk(dat_r, 8'h5a);
      apb(0, 1, OFS_DONE_RAW, 0);
      apb(0, 0, OFS_DATA, 0);
      poll;
      apb(0, 0, OFS_CAPTURE, 0);
      chk(q, 32'h5a);
      apb(0, 1, OFS_DONE_MASK, 1);
      apb(0, 0, OFS_DONE_STAT, 0);
      chk(q, 1);
      chk(irq, 1);
      apb(0, 1, OFS_DONE_RAW, 0);
      apb(0, 0, OFS_DONE_STAT, 0);
      chk(q, 0);
      chk(irq, 0);
   endtask : t_data
   // command write, then a data write refused mid-cycle
   task automatic t_cmd;
      apb(0, 1, OFS_DONE_MASK, 0);
      apb(0, 1, OFS_CMD_BUSY, 32'h012c);
      apb(0, 1, OFS_DATA, 32'h77);
      poll;
      chk(cmd_r, 8'h2c);
      chk(dat_r, 8'h5a);
      chk(irq, 0);
      apb(0, 1, OFS_DONE_RAW, 0);
      apb(0, 0, OFS_CMD_BUSY, 0);
      poll;
      apb(0, 0, OFS_CAPTURE, 0);
      chk(q, BUSY_VAL);
   endtask : t_cmd
   task automatic t_tw;
      rd_tw;
      chk(q, 3);
      apb(1, 1, OFS_TW_CLEAR, 3);
      rd_tw;
      chk(q, 0);
      apb(1, 1, OFS_TW_LINE, 1);
      rd_tw;
      chk(q, 1);
      sda_hold <= 1;
      apb(1, 1, OFS_TW_LINE, 2);
      rd_tw;
      chk(q, 1);
      sda_hold <= 0;
      rd_tw;
      chk(q, 3);
   endtask : t_tw
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      t_pins;
      t_data;
      t_cmd;
      t_tw;
      close_out;
   end
   // watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      close_out;
   end
endmodule : lcd_parallel_touch_port_tb

// >>> sim/lcd_port_asserts.sv
`timescale 1ns/1ps
module lcd_port_checker (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        lcd_psel,
   input wire logic        lcd_penable,
   input wire logic        lcd_pwrite,
   input wire logic [11:0] lcd_paddr,
   input wire logic [31:0] lcd_pwdata,
   input wire logic [31:0] lcd_prdata,
   input wire logic        lcd_pready,
   input wire logic        lcd_pslverr,
   input wire logic        tw_psel,
   input wire logic        tw_penable,
   input wire logic        tw_pready,
   input wire logic        tw_pslverr,
   input wire logic        lcd_data_oe,
   input wire logic        lcd_chip_select,
   input wire logic        lcd_write_strobe,
   input wire logic        lcd_read_strobe,
   input wire logic        lcd_register_select,
   input wire logic        lcd_reset_line,
   input wire logic        lcd_backlight,
   input wire logic        lcd_done_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // access decodes and bus idle
   wire lwr = lcd_psel && lcd_penable && lcd_pwrite;
   wire lrd = lcd_psel && lcd_penable && !lcd_pwrite;
   wire idle = !lcd_chip_select && !lcd_write_strobe && !lcd_read_strobe;
   // mask bit as last written, tracked from the bus
   logic mask_seen;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         mask_seen <= 1'b0;
      else if (lwr && lcd_paddr == 12'h010)
         mask_seen <= lcd_pwdata[0];
   end
   // one setup cycle, three strobe cycles, then hold
   sequence wr_pulse; !lcd_write_strobe ##1 lcd_write_strobe[*3] ##1 !lcd_write_strobe; endsequence
   sequence rd_pulse; !lcd_read_strobe ##1 lcd_read_strobe[*3] ##1 !lcd_read_strobe; endsequence
   chk_cmd_write: assert property (lwr && lcd_paddr == 12'h000 && idle |=>
      !lcd_register_select ##0 wr_pulse) else $error("command write cycle wrong");
   chk_data_write: assert property (lwr && lcd_paddr == 12'h004 && idle |=>
      lcd_register_select ##0 wr_pulse) else $error("data write cycle wrong");
   chk_busy_read: assert property (lrd && lcd_paddr == 12'h000 && idle |=>
      !lcd_register_select ##0 rd_pulse) else $error("busy read cycle wrong");
   chk_data_read: assert property (lrd && lcd_paddr == 12'h004 && idle |=>
      lcd_register_select ##0 rd_pulse) else $error("data read cycle wrong");
   chk_select_frame: assert property (lcd_psel && lcd_penable && idle && lcd_paddr[11:3] == 0
      |=> lcd_chip_select[*5] ##1 !lcd_chip_select) else $error("chip select frame wrong");
   chk_pin_out: assert property (lwr && lcd_paddr == 12'h04c |=>
      lcd_reset_line == $past(lcd_pwdata[3]) && lcd_backlight == $past(lcd_pwdata[6]))
      else $error("reset or backlight pin wrong");
   chk_stat_read: assert property (lrd && lcd_paddr == 12'h014 |->
      lcd_prdata == {31'h0, lcd_done_irq}) else $error("masked status wrong");
   chk_capture_upper: assert property (lrd && lcd_paddr == 12'h008 |->
      lcd_prdata[31:8] == 24'h0) else $error("capture upper bits set");
   // data bus driven for the whole write cycle, never during a read
   chk_data_drive: assert property (lwr && lcd_paddr[11:3] == 0 && idle |=>
      lcd_data_oe[*5] ##1 !lcd_data_oe) else $error("data bus drive wrong on write");
   chk_read_float: assert property (lrd && lcd_paddr[11:3] == 0 && idle |=>
      !lcd_data_oe[*6]) else $error("data bus driven during read");
   // interrupt gated by the written mask and dropped by a raw clear
   chk_irq_masked: assert property (!mask_seen |-> !lcd_done_irq)
      else $error("interrupt while masked");
   chk_irq_clear: assert property (lwr && lcd_paddr == 12'h00c && idle
      && !lcd_pwdata[0] |=> !lcd_done_irq) else $error("interrupt not cleared");
   // both slots answer every access at once without error
   chk_zero_wait: assert property ((lcd_psel && lcd_penable) || (tw_psel && tw_penable) |->
      lcd_pready && !lcd_pslverr && tw_pready && !tw_pslverr) else $error("bus not zero wait");
endmodule : lcd_port_checker

bind lcd_parallel_touch_port lcd_port_checker i_chk (.sys_clk, .rst, .lcd_psel, .lcd_penable,
   .lcd_pwrite, .lcd_paddr, .lcd_pwdata, .lcd_prdata, .lcd_pready, .lcd_pslverr, .tw_psel,
   .tw_penable, .tw_pready, .tw_pslverr, .lcd_data_oe, .lcd_chip_select, .lcd_write_strobe,
   .lcd_read_strobe, .lcd_register_select, .lcd_reset_line, .lcd_backlight, .lcd_done_irq);

// >>> verilog/lcd_parallel_touch_port.sv
`timescale 1ns/1ps
// Function
// - write offset 0 sends lcd command
// - read offset 0 reads lcd busy register
// - write offset 4 sends lcd data
// - read offset 4 starts lcd data read
// - capture register holds last read byte
// - access complete set at the end of every bus cycle, read or write
// - writing zero clears access complete
// - mask bit one enables interrupt
// - masked status equals flag and mask
// - pin control drives cs wr rs rd
// - pin control drives reset and backlight
// - two-wire read returns scl sda
// - two-wire set write sets ones
// - two-wire clear write clears ones
module lcd_parallel_touch_port
   import lcd_port_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // lcd register slot, apb
   input  wire logic        lcd_psel,
   input  wire logic        lcd_penable,
   input  wire logic        lcd_pwrite,
   input  wire logic [11:0] lcd_paddr,
   input  wire logic [31:0] lcd_pwdata,
   output logic      [31:0] lcd_prdata,
   output logic             lcd_pready,
   output logic             lcd_pslverr,
   // two-wire register slot, apb
   input  wire logic        tw_psel,
   input  wire logic        tw_penable,
   input  wire logic        tw_pwrite,
   input  wire logic [11:0] tw_paddr,
   input  wire logic [31:0] tw_pwdata,
   output logic      [31:0] tw_prdata,
   output logic             tw_pready,
   output logic             tw_pslverr,
   // parallel lcd bus
   input  wire logic [7:0]  lcd_data_in,
   output logic      [7:0]  lcd_data_out,
   output logic             lcd_data_oe,
   output logic             lcd_chip_select,
   output logic             lcd_write_strobe,
   output logic             lcd_read_strobe,
   output logic             lcd_register_select,
   output logic             lcd_reset_line,
   output logic             lcd_backlight,
   output logic             lcd_done_irq,
   // touch two-wire lines
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe
);
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SETUP  = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_HOLD   = 4'b1000
   } cyc_state_e;

   localparam logic [2:0] SETUP_LEN  = 3'(SETUP_CYCLES);
   localparam logic [2:0] STROBE_LEN = 3'(STROBE_CYCLES);

   cyc_state_e  state_r;
   cyc_state_e  state_nxt;
   logic [2:0]  cnt_r;
   logic [2:0]  cnt_nxt;
   logic        is_read_r;
   logic        rs_r;
   logic [7:0]  wdata_r;
   logic [7:0]  capture_r;
   logic        done_r;
   logic        mask_r;
   logic [6:0]  pin_ctrl_r;
   logic [7:0]  data_sync;

   // apb decode
   wire lcd_acc     = lcd_psel & lcd_penable;
   wire idle        = (state_r == ST_IDLE);
   wire port_hit    = (lcd_paddr == OFS_CMD_BUSY) | (lcd_paddr == OFS_DATA);
   wire start_cyc   = lcd_acc & port_hit & idle;
   wire wr_raw      = lcd_acc & lcd_pwrite & (lcd_paddr == OFS_DONE_RAW);
   wire wr_mask     = lcd_acc & lcd_pwrite & (lcd_paddr == OFS_DONE_MASK);
   wire wr_pins     = lcd_acc & lcd_pwrite & (lcd_paddr == OFS_PIN_CTRL);
   wire rd_done     = (state_r == ST_HOLD) & is_read_r;
   wire cyc_end     = (state_r == ST_HOLD);

   // incoming lcd data is from another domain
   sync_2ff #(.WIDTH(8), .INIT(8'h00)) u_data_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       (lcd_data_in),
      .q       (data_sync)
   );

   // bus cycle sequencer: setup, strobe, hold
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (start_cyc) begin
               state_nxt = ST_SETUP;
               cnt_nxt   = SETUP_LEN;
            end
         end
         ST_SETUP: begin
            if (cnt_r == 3'h1) begin
               state_nxt = ST_STROBE;
               cnt_nxt   = STROBE_LEN;
            end else
               cnt_nxt = cnt_r - 3'h1;
         end
         ST_STROBE: begin
            if (cnt_r == 3'h1)
               state_nxt = ST_HOLD;
            else
               cnt_nxt = cnt_r - 3'h1;
         end
         ST_HOLD: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cnt_r   <= 3'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // latch the access kind when a cycle starts
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         is_read_r <= 1'b0;
         rs_r      <= 1'b0;
         wdata_r   <= 8'h00;
      end else if (start_cyc) begin
         is_read_r <= ~lcd_pwrite;
         rs_r      <= (lcd_paddr == OFS_DATA);
         wdata_r   <= lcd_pwdata[7:0];
      end
   end

   // read byte captured at end of the hold cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         capture_r <= 8'h00;
      else if (rd_done)
         capture_r <= data_sync;
   end

   // access complete: a set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         done_r <= 1'b0;
      else if (cyc_end)
         done_r <= 1'b1;
      else if (wr_raw & ~lcd_pwdata[0])
         done_r <= 1'b0;
   end

   // interrupt mask and pin control
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_r     <= 1'b0;
         pin_ctrl_r <= PIN_CTRL_RESET;
      end else begin
         if (wr_mask)
            mask_r <= lcd_pwdata[0];
         if (wr_pins)
            pin_ctrl_r <= lcd_pwdata[6:0] & PIN_CTRL_MASK;
      end
   end

   // hardware cycle is ORed with software strobes, register select follows the cycle while active
   wire cyc_active = ~idle;
   wire strobe_on  = (state_r == ST_STROBE);
   assign lcd_chip_select     = cyc_active | pin_ctrl_r[BIT_CS];
   assign lcd_write_strobe    = (strobe_on & ~is_read_r) | pin_ctrl_r[BIT_WR];
   assign lcd_read_strobe     = (strobe_on & is_read_r) | pin_ctrl_r[BIT_RD];
   assign lcd_register_select = cyc_active ? rs_r : pin_ctrl_r[BIT_RS];
   assign lcd_reset_line      = pin_ctrl_r[BIT_RST];
   assign lcd_backlight       = pin_ctrl_r[BIT_BL];
   assign lcd_data_out        = wdata_r;
   assign lcd_data_oe         = cyc_active & ~is_read_r;

   // interrupt follows the masked flag
   wire masked_done = done_r & mask_r;
   assign lcd_done_irq = masked_done;

   // read mux, reserved bits zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      case (lcd_paddr)
         OFS_CAPTURE:   rd_mux = {24'h0, capture_r};
         OFS_DONE_RAW:  rd_mux = {31'h0, done_r};
         OFS_DONE_STAT: rd_mux = {31'h0, masked_done};
         OFS_PIN_CTRL:  rd_mux = {25'h0, pin_ctrl_r};
         default:       rd_mux = 32'h0;
      endcase
   end
   assign lcd_prdata  = rd_mux;
   assign lcd_pready  = 1'b1;
   assign lcd_pslverr = 1'b0;

   twowire_bitbang_controller u_twowire (
      .sys_clk (sys_clk),
      .rst     (rst),
      .psel    (tw_psel),
      .penable (tw_penable),
      .pwrite  (tw_pwrite),
      .paddr   (tw_paddr),
      .pwdata  (tw_pwdata),
      .prdata  (tw_prdata),
      .pready  (tw_pready),
      .pslverr (tw_pslverr),
      .scl_in  (scl_in),
      .scl_out (scl_out),
      .scl_oe  (scl_oe),
      .sda_in  (sda_in),
      .sda_out (sda_out),
      .sda_oe  (sda_oe)
   );
endmodule : lcd_parallel_touch_port

// >>> verilog/lcd_port_pkg.sv
package lcd_port_pkg;
   // lcd slot offsets
   localparam logic [11:0] OFS_CMD_BUSY  = 12'h000;
   localparam logic [11:0] OFS_DATA      = 12'h004;
   localparam logic [11:0] OFS_CAPTURE   = 12'h008;
   localparam logic [11:0] OFS_DONE_RAW  = 12'h00c;
   localparam logic [11:0] OFS_DONE_MASK = 12'h010;
   localparam logic [11:0] OFS_DONE_STAT = 12'h014;
   localparam logic [11:0] OFS_PIN_CTRL  = 12'h04c;
   // two-wire slot offsets
   localparam logic [11:0] OFS_TW_LINE   = 12'h000;
   localparam logic [11:0] OFS_TW_CLEAR  = 12'h004;
   // pin control field positions
   localparam int BIT_CS    = 0;
   localparam int BIT_WR    = 1;
   localparam int BIT_RST   = 3;
   localparam int BIT_RS    = 4;
   localparam int BIT_RD    = 5;
   localparam int BIT_BL    = 6;
   localparam logic [6:0] PIN_CTRL_MASK  = 7'h7b;
   // reset values
   localparam logic [6:0] PIN_CTRL_RESET = 7'h00;
   localparam logic [1:0] TW_LINE_RESET  = 2'h3;
   // parallel bus cycle timing, in ns and cycles of the 40 ns clock
   localparam int CLK_PERIOD_NS  = 40;
   localparam int STROBE_NS      = 120;
   localparam int STROBE_CYCLES  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_NS       = 40;
   localparam int SETUP_CYCLES   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lcd_port_pkg

// >>> verilog/sync_2ff.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module sync_2ff #(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sync_2ff

// >>> verilog/twowire_bitbang_controller.sv
`timescale 1ns/1ps
// bit-banged two-wire line controller for the touch expander
module twowire_bitbang_controller
   import lcd_port_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe
);
   logic [1:0] line_r;
   logic [1:0] line_nxt;
   logic [1:0] pins_sync;
   wire        wr_set   = psel & penable & pwrite & (paddr == OFS_TW_LINE);
   wire        wr_clear = psel & penable & pwrite & (paddr == OFS_TW_CLEAR);

   sync_2ff #(.WIDTH(2), .INIT(TW_LINE_RESET)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       ({sda_in, scl_in}),
      .q       (pins_sync)
   );

   // set and clear writes touch only bits holding a one
   always_comb begin
      line_nxt = line_r;
      if (wr_set)
         line_nxt = line_r | pwdata[1:0];
      else if (wr_clear)
         line_nxt = line_r & ~pwdata[1:0];
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         line_r <= TW_LINE_RESET;
      else
         line_r <= line_nxt;
   end

   // open drain: pull low on zero, release on one
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = ~line_r[0];
   assign sda_oe  = ~line_r[1];

   // line state read back, upper bits zero
   assign prdata  = (paddr == OFS_TW_LINE) ? {30'h0, pins_sync} : 32'h0;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
endmodule : twowire_bitbang_controller
